//--- logic/rscd_pkg.sv
// Package of constants for the reset, strap and default configuration block
package rscd_pkg;
   // Clock and reset pulse timing
   localparam int CLK_MHZ = 125;
   localparam int RESET_MIN_NS = 2000;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_CNT_W = 9;
   // Baud rates selectable by strap
   localparam logic [31:0] BAUD_HIGH = 32'h0000_9600;
   localparam logic [31:0] BAUD_LOW = 32'h0000_2580;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_BAUD_PARAM = 8'h08;
   localparam logic [7:0] OFS_BAUD = 8'h0C;
   localparam logic [7:0] OFS_CMD = 8'h10;
   // Control register fields
   localparam int CTRL_BAUD_PARAM_EN = 0;
   localparam int CTRL_SUPPLY_INVERT = 1;
   localparam int CTRL_VARIANT_VPW = 2;
   localparam int CTRL_BUS_PLUS = 3;
   localparam int CTRL_STANDBY = 4;
   // Command register codes
   localparam logic [3:0] CMD_MEM_ON = 4'h1;
   localparam logic [3:0] CMD_MEM_OFF = 4'h2;
   localparam logic [3:0] CMD_LF_ON = 4'h3;
   localparam logic [3:0] CMD_LF_OFF = 4'h4;
   // Reset values
   localparam logic [4:0] CTRL_RESET = 5'h04;
   localparam logic [31:0] BAUD_PARAM_RESET = 32'h0000_9600;
endpackage

//--- logic/rscd_top.sv
// Reset pulse filter, strap capture and default configuration with APB registers
`timescale 1ns/1ps

module rscd_top (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic master_reset_in, // Reset pin, low active
   input wire logic memory_strap_in, // Memory default strap
   input wire logic baud_strap_in, // Baud default strap
   input wire logic linefeed_strap_in, // Linefeed default strap
   input wire logic bus_plus_req, // Bus plus active request
   output logic system_reset_n, // Filtered reset, low active
   output logic memory_enable, // Memory option state
   output logic linefeed_enable, // CR+LF when high
   output logic [31:0] baud_rate, // Active baud rate
   output logic bus_plus_supply_select_out, // High selects 8V
   output logic bus_plus_drive_out, // Bus plus drive
   output logic osc_enable // Oscillator run enable
);
   logic [2:0] mr_sync_reg;
   logic [2:0] mem_sync_reg;
   logic [2:0] baud_sync_reg;
   logic [2:0] lf_sync_reg;
   logic [rscd_pkg::RESET_CNT_W-1:0] low_cnt_reg;
   logic mr_low_reg;
   logic sys_rst_reg;
   logic sample_reg;
   logic mem_reg;
   logic lf_reg;
   logic baud_strap_reg;
   logic [4:0] ctrl_reg;
   logic [31:0] baud_param_reg;
   logic [31:0] prdata_reg;
   logic wr_en;
   logic rd_en;
   logic addr_ok;

   // APB always answers in the access cycle
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign addr_ok = (paddr == rscd_pkg::OFS_CTRL) || (paddr == rscd_pkg::OFS_STATUS)
      || (paddr == rscd_pkg::OFS_BAUD_PARAM) || (paddr == rscd_pkg::OFS_BAUD)
      || (paddr == rscd_pkg::OFS_CMD);
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = prdata_reg;

   // Pin synchronisers, three flops each
   // Reset pin starts as if held low, so reset lasts until the straps are through
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mr_sync_reg <= 3'h0;
         mem_sync_reg <= 3'h0;
         baud_sync_reg <= 3'h0;
         lf_sync_reg <= 3'h0;
      end
      else
      begin
         mr_sync_reg <= {mr_sync_reg[1:0], master_reset_in};
         mem_sync_reg <= {mem_sync_reg[1:0], memory_strap_in};
         baud_sync_reg <= {baud_sync_reg[1:0], baud_strap_in};
         lf_sync_reg <= {lf_sync_reg[1:0], linefeed_strap_in};
      end
   end

   // Reset pin level, changes only when stages 2 and 3 agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mr_low_reg <= 1'b1;
      else if (mr_sync_reg[1] == mr_sync_reg[2])
         mr_low_reg <= !mr_sync_reg[2];
   end

   // Low pulse width counter; short glitches never reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_cnt_reg <= '0;
      else if (!mr_low_reg)
         low_cnt_reg <= '0;
      else if (low_cnt_reg != rscd_pkg::RESET_CNT_W'(rscd_pkg::RESET_MIN_CYC))
         low_cnt_reg <= low_cnt_reg + 1'b1;
   end

   // System reset held until pin released after a long enough pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sys_rst_reg <= 1'b1;
      else if (low_cnt_reg == rscd_pkg::RESET_CNT_W'(rscd_pkg::RESET_MIN_CYC))
         sys_rst_reg <= 1'b1;
      else if (!mr_low_reg)
         sys_rst_reg <= 1'b0;
   end
   assign system_reset_n = !sys_rst_reg;

   // Sample flag: reset delayed one cycle, so it also covers the first cycle after any reset ends
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sample_reg <= 1'b0;
      else
         sample_reg <= sys_rst_reg;
   end

   // Memory option: strap at reset, commands afterwards
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mem_reg <= 1'b0;
      else if (sys_rst_reg || sample_reg)
         mem_reg <= mem_sync_reg[2];
      else if (wr_en && paddr == rscd_pkg::OFS_CMD)
      begin
         if (pwdata[3:0] == rscd_pkg::CMD_MEM_ON)
            mem_reg <= 1'b1;
         else if (pwdata[3:0] == rscd_pkg::CMD_MEM_OFF)
            mem_reg <= 1'b0;
      end
   end

   // Linefeed mode: strap at reset, commands afterwards
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lf_reg <= 1'b0;
      else if (sys_rst_reg || sample_reg)
         lf_reg <= lf_sync_reg[2];
      else if (wr_en && paddr == rscd_pkg::OFS_CMD)
      begin
         if (pwdata[3:0] == rscd_pkg::CMD_LF_ON)
            lf_reg <= 1'b1;
         else if (pwdata[3:0] == rscd_pkg::CMD_LF_OFF)
            lf_reg <= 1'b0;
      end
   end

   // Baud strap latched only around reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         baud_strap_reg <= 1'b0;
      else if (sys_rst_reg || sample_reg)
         baud_strap_reg <= baud_sync_reg[2];
   end

   // Control and baud parameter registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= rscd_pkg::CTRL_RESET;
         baud_param_reg <= rscd_pkg::BAUD_PARAM_RESET;
      end
      else if (sys_rst_reg)
      begin
         ctrl_reg <= rscd_pkg::CTRL_RESET;
         baud_param_reg <= rscd_pkg::BAUD_PARAM_RESET;
      end
      else if (wr_en && paddr == rscd_pkg::OFS_CTRL)
         ctrl_reg <= pwdata[4:0];
      else if (wr_en && paddr == rscd_pkg::OFS_BAUD_PARAM)
         baud_param_reg <= pwdata;
   end

   // Baud selection; parameter only applies with strap high
   always_comb
   begin
      if (!baud_strap_reg)
         baud_rate = rscd_pkg::BAUD_LOW;
      else if (ctrl_reg[rscd_pkg::CTRL_BAUD_PARAM_EN])
         baud_rate = baud_param_reg;
      else
         baud_rate = rscd_pkg::BAUD_HIGH;
   end

   // Pin outputs; invert bit models the supply parameter
   assign bus_plus_supply_select_out = ctrl_reg[rscd_pkg::CTRL_VARIANT_VPW]
      ^ ctrl_reg[rscd_pkg::CTRL_SUPPLY_INVERT];
   assign bus_plus_drive_out = bus_plus_req && !sys_rst_reg;
   assign osc_enable = !ctrl_reg[rscd_pkg::CTRL_STANDBY];
   assign memory_enable = mem_reg;
   assign linefeed_enable = lf_reg;

   // Read data register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         case (paddr)
            rscd_pkg::OFS_CTRL: prdata_reg <= {27'h0, ctrl_reg};
            rscd_pkg::OFS_STATUS: prdata_reg <= {28'h0, baud_strap_reg, lf_reg, mem_reg,
               sys_rst_reg};
            rscd_pkg::OFS_BAUD_PARAM: prdata_reg <= baud_param_reg;
            rscd_pkg::OFS_BAUD: prdata_reg <= baud_rate;
            default: prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // Assertions
   property p_long_low_resets;
      @(posedge pclk) disable iff (!presetn)
      (low_cnt_reg == rscd_pkg::RESET_CNT_W'(rscd_pkg::RESET_MIN_CYC)) |=> !system_reset_n;
   endproperty
   a_long_low_resets: assert property (p_long_low_resets) else $error("long low no reset");

   property p_mem_strap;
      @(posedge pclk) disable iff (!presetn)
      sample_reg |=> (memory_enable == $past(mem_sync_reg[2]));
   endproperty
   a_mem_strap: assert property (p_mem_strap) else $error("memory strap not taken");

   property p_mem_cmd;
      @(posedge pclk) disable iff (!presetn)
      (!sys_rst_reg && !sample_reg && wr_en && paddr == rscd_pkg::OFS_CMD
         && pwdata[3:0] == rscd_pkg::CMD_MEM_ON) |=> memory_enable;
   endproperty
   a_mem_cmd: assert property (p_mem_cmd) else $error("memory on lost");

   property p_baud_low;
      @(posedge pclk) disable iff (!presetn)
      !baud_strap_reg |-> baud_rate == rscd_pkg::BAUD_LOW;
   endproperty
   a_baud_low: assert property (p_baud_low) else $error("baud low wrong");

   property p_lf_strap;
      @(posedge pclk) disable iff (!presetn)
      sample_reg |=> (linefeed_enable == $past(lf_sync_reg[2]));
   endproperty
   a_lf_strap: assert property (p_lf_strap) else $error("linefeed strap not taken");

   property p_lf_cmd;
      @(posedge pclk) disable iff (!presetn)
      (!sys_rst_reg && !sample_reg && wr_en && paddr == rscd_pkg::OFS_CMD
         && pwdata[3:0] == rscd_pkg::CMD_LF_OFF) |=> !linefeed_enable;
   endproperty
   a_lf_cmd: assert property (p_lf_cmd) else $error("linefeed off lost");

   property p_supply;
      @(posedge pclk) disable iff (!presetn)
      bus_plus_supply_select_out == (ctrl_reg[rscd_pkg::CTRL_VARIANT_VPW]
         != ctrl_reg[rscd_pkg::CTRL_SUPPLY_INVERT]);
   endproperty
   a_supply: assert property (p_supply) else $error("supply select wrong");

   property p_drive;
      @(posedge pclk) disable iff (!presetn)
      !system_reset_n |-> !bus_plus_drive_out;
   endproperty
   a_drive: assert property (p_drive) else $error("drive in reset");

   property p_strap_hold;
      @(posedge pclk) disable iff (!presetn)
      (!sys_rst_reg && !sample_reg) |=> $stable(baud_strap_reg);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed late");

   // Filtered reset lifting is a two step event
   sequence s_reset_lifts;
      !system_reset_n ##1 system_reset_n;
   endsequence

   property p_sample_after;
      @(posedge pclk) disable iff (!presetn)
      s_reset_lifts |-> sample_reg;
   endproperty
   a_sample_after: assert property (p_sample_after)
      else $error("strap window missed");

   property p_short_low;
      @(posedge pclk) disable iff (!presetn)
      (system_reset_n && low_cnt_reg != rscd_pkg::RESET_CNT_W'(rscd_pkg::RESET_MIN_CYC))
         |=> system_reset_n;
   endproperty
   a_short_low: assert property (p_short_low) else $error("short low reset");

   property p_drive_on;
      @(posedge pclk) disable iff (!presetn)
      (bus_plus_req && system_reset_n) |-> bus_plus_drive_out;
   endproperty
   a_drive_on: assert property (p_drive_on) else $error("drive not on");

   property p_baud_high;
      @(posedge pclk) disable iff (!presetn)
      (baud_strap_reg && !ctrl_reg[rscd_pkg::CTRL_BAUD_PARAM_EN])
         |-> baud_rate == rscd_pkg::BAUD_HIGH;
   endproperty
   a_baud_high: assert property (p_baud_high) else $error("baud high wrong");

   property p_standby;
      @(posedge pclk) disable iff (!presetn)
      ctrl_reg[rscd_pkg::CTRL_STANDBY] |-> !osc_enable;
   endproperty
   a_standby: assert property (p_standby) else $error("oscillator runs in standby");
endmodule

//--- verif/rscd_board.sv
// Board model: strap resistors and the reset push button
`timescale 1ns/1ps
module rscd_board (
   input wire logic pclk, // Board clock reference
   input wire logic [2:0] strap_sel, // Strap levels {baud, linefeed, memory}
   output logic master_reset_in, // Reset pin, low active
   output logic memory_strap_in, // Memory strap level
   output logic baud_strap_in, // Baud strap level
   output logic linefeed_strap_in // Linefeed strap level
);
   // Pull-up keeps the pin high whenever nobody presses the button
   initial master_reset_in = 1'b1;

   // Straps are plain resistor levels that the bench can move
   assign memory_strap_in = strap_sel[0];
   assign linefeed_strap_in = strap_sel[1];
   assign baud_strap_in = strap_sel[2];

   // Low pulse of n clocks on the reset pin, edge aligned
   task pulse(input int n);
      master_reset_in <= 1'b0;
      repeat (n) @(posedge pclk);
      master_reset_in <= 1'b1;
   endtask
endmodule

//--- verif/test_reset_strap_config_defaults.sv
// Self-checking bench for reset, strap capture and default configuration
`timescale 1ns/1ps
module test_reset_strap_config_defaults;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bus_plus_req = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, baud_rate, rd, m_param;
   logic [2:0] strap_sel = 3'h0;
   logic pready, pslverr, master_reset_in, memory_strap_in, baud_strap_in, linefeed_strap_in;
   logic system_reset_n, memory_enable, linefeed_enable, bus_plus_supply_select_out;
   logic bus_plus_drive_out, osc_enable;
   int n_fail = 0, num_checks = 0, seed = 32'hddb933a6, m_mem, m_lf, m_bs, m_ctrl, i;

   rscd_top rscd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .master_reset_in, .memory_strap_in, .baud_strap_in,
      .linefeed_strap_in, .bus_plus_req, .system_reset_n, .memory_enable,
      .linefeed_enable, .baud_rate, .bus_plus_supply_select_out, .bus_plus_drive_out,
      .osc_enable);
   rscd_board rscd_board_inst (.pclk, .strap_sel, .master_reset_in, .memory_strap_in,
      .baud_strap_in, .linefeed_strap_in);

   // 125 MHz clock
   always #4 pclk = ~pclk;

   task final_report;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         n_fail++;
         final_report;
      end
      // One more edge so registered results have settled before any compare
      @(posedge pclk);
   endtask

   // Bounded wait for the filtered reset to lift, plus one idle cycle
   task wait_up;
      int k;
      k = 0;
      while (system_reset_n !== 1'b1 && k < 400)
      begin
         @(posedge pclk);
         k++;
      end
      if (system_reset_n !== 1'b1)
      begin
         n_fail++;
         final_report;
      end
      @(posedge pclk);
   endtask

   // Reference model: straps taken at reset, ctrl and param from writes
   function logic [31:0] exp_baud();
      if (m_bs == 0)
         return rscd_pkg::BAUD_LOW;
      return m_ctrl[0] ? m_param : rscd_pkg::BAUD_HIGH;
   endfunction

   task take_straps;
      m_mem = strap_sel[0];
      m_lf = strap_sel[1];
      m_bs = strap_sel[2];
   endtask

   task cmp_all;
      chk(memory_enable, m_mem, "memory option");
      chk(linefeed_enable, m_lf, "line ending");
      chk(baud_rate, exp_baud(), "baud rate");
      chk(bus_plus_supply_select_out, m_ctrl[2] ^ m_ctrl[1], "supply select");
      chk(osc_enable, !m_ctrl[4], "oscillator enable");
   endtask

   initial
   begin
      m_param = rscd_pkg::BAUD_PARAM_RESET;
      // Every strap combination through an APB reset
      for (i = 0; i < 8; i++)
      begin
         strap_sel <= i[2:0];
         presetn <= 1'b0;
         repeat (6) @(posedge pclk);
         presetn <= 1'b1;
         wait_up;
         take_straps;
         m_ctrl = rscd_pkg::CTRL_RESET;
         cmp_all;
         apb(1'b0, rscd_pkg::OFS_CTRL, 32'h0);
         chk(rd, rscd_pkg::CTRL_RESET, "ctrl reset value");
         apb(1'b0, rscd_pkg::OFS_BAUD_PARAM, 32'h0);
         chk(rd, rscd_pkg::BAUD_PARAM_RESET, "param reset value");
         strap_sel <= ~i[2:0];
         repeat (4) @(posedge pclk);
         cmp_all;
      end
      $display("strap capture test done");
      // All four option commands
      for (i = 1; i < 5; i++)
      begin
         apb(1'b1, rscd_pkg::OFS_CMD, i);
         m_mem = (i == 1) ? 1 : (i == 2) ? 0 : m_mem;
         m_lf = (i == 3) ? 1 : (i == 4) ? 0 : m_lf;
         cmp_all;
      end
      $display("command test done");
      // Random baud parameter, then every control value
      m_param = $random(seed);
      apb(1'b1, rscd_pkg::OFS_BAUD_PARAM, m_param);
      for (i = 0; i < 32; i++)
      begin
         apb(1'b1, rscd_pkg::OFS_CTRL, i);
         m_ctrl = i;
         cmp_all;
         apb(1'b0, rscd_pkg::OFS_BAUD, 32'h0);
         chk(rd, exp_baud(), "baud register");
      end
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0, "unmapped read data");
      chk(err, 1'b1, "unmapped read error");
      $display("control test done");
      // Bus plus drive follows its request
      chk(bus_plus_drive_out, 1'b0, "bus plus off");
      bus_plus_req <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(bus_plus_drive_out, 1'b1, "bus plus on");
      apb(1'b1, rscd_pkg::OFS_CTRL, rscd_pkg::CTRL_RESET);
      m_ctrl = rscd_pkg::CTRL_RESET;
      // Short pin pulse ignored, long one resets and retakes straps
      strap_sel <= 3'($random(seed));
      rscd_board_inst.pulse(100);
      repeat (6) @(posedge pclk);
      chk(system_reset_n, 1'b1, "short pulse");
      rscd_board_inst.pulse(260);
      chk(system_reset_n, 1'b0, "long pulse");
      chk(bus_plus_drive_out, 1'b0, "bus plus in reset");
      wait_up;
      take_straps;
      cmp_all;
      $display("pin reset test done");
      final_report;
   end
endmodule
